// ---- src/cdm_consts.svh ----
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH

// Local special function register addresses
`define CDM_STACK_TOP_PTR_ADDR 8'h81
`define CDM_STORE_CTL_ADDR 8'h8f
`define CDM_STATUS_WORD_ADDR 8'hd0

// Reset values
`define CDM_STACK_TOP_PTR_RESET 8'h07
`define CDM_STORE_CTL_RESET 8'h00
`define CDM_STATUS_WORD_RESET 8'h00
`define CDM_RAM_RESET 8'h00

// Field positions
`define CDM_BANK_SELECT_LOW_BIT 3
`define CDM_BANK_SELECT_HIGH_BIT 4
`define CDM_STORE_WRITE_EN_BIT 0

// Memory layout
`define CDM_RAM_DEPTH 256
`define CDM_BIT_RAM_BASE 8'h20
`define CDM_PROG_TOP_64K 16'hfbff

// Opcodes
`define CDM_NO_OPERATION_OPCODE 8'h00
`define CDM_SPARE_OPCODE 8'ha5

`endif

// ---- src/cdm_data_memory.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cdm_consts.svh"

module cdm_data_memory
  import cdm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic accReq,
  input wire cdm_access_type accMode,
  input wire logic accWrite,
  input wire logic [7:0] accAddr,
  input wire logic [7:0] accWData,
  input wire logic accWBit,
  output logic accRdValid,
  output logic [7:0] accRdData,
  output logic accRdBit,
  output logic sfrSel,
  output logic sfrWe,
  output logic [7:0] sfrAddr,
  output logic [7:0] sfrWData,
  input wire logic [7:0] sfrRdData,
  output logic [7:0] stackTopPointer,
  output logic [7:0] processorStatusWord,
  output logic [7:0] programStoreWriteControl,
  input wire logic brReq,
  input wire cdm_branch_type brKind,
  input wire logic [15:0] brNextPc,
  input wire logic [15:0] brOperand,
  output logic brValid,
  output logic [15:0] brTarget,
  input wire logic opReq,
  input wire logic [7:0] opCode,
  input wire logic [15:0] opPc,
  output logic opNoOperation,
  output logic [15:0] opNoOperationNextPc,
  input wire logic xdataWrReq,
  input wire logic [15:0] xdataWrAddr,
  input wire logic [7:0] xdataWrData,
  output logic progWrEn,
  output logic xdataWrEn,
  output logic [15:0] memWrAddr,
  output logic [7:0] memWrData
);

  logic [7:0] ram_reg [`CDM_RAM_DEPTH];
  logic [7:0] ram_next [`CDM_RAM_DEPTH];
  logic [7:0] stackPtr_reg;
  logic [7:0] stackPtr_next;
  logic [7:0] statusWord_reg;
  logic [7:0] statusWord_next;
  logic [7:0] storeCtl_reg;
  logic [7:0] storeCtl_next;
  logic rdValid_reg;
  logic rdValid_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic rdBit_reg;
  logic rdBit_next;
  logic brValid_reg;
  logic brValid_next;
  logic [15:0] brTarget_reg;
  logic [15:0] brTarget_next;
  logic noOp_reg;
  logic noOp_next;
  logic [15:0] noOpPc_reg;
  logic [15:0] noOpPc_next;
  logic progWrEn_reg;
  logic progWrEn_next;
  logic xdataWrEn_reg;
  logic xdataWrEn_next;
  logic [15:0] wrAddr_reg;
  logic [15:0] wrAddr_next;
  logic [7:0] wrData_reg;
  logic [7:0] wrData_next;

  logic [7:0] tgtAddr;
  logic tgtSfr;
  logic tgtLocal;
  logic [7:0] localValue;
  logic [7:0] oldValue;
  logic [7:0] newValue;
  logic doWrite;
  logic [2:0] bitPos;

  // Working register address in the active bank
  function automatic logic [7:0] bankRegAddr(input logic [7:0] status, input logic [2:0] idx);
    return {3'b000, status[`CDM_BANK_SELECT_HIGH_BIT], status[`CDM_BANK_SELECT_LOW_BIT], idx};
  endfunction : bankRegAddr

  // Byte holding a given bit address
  function automatic logic [7:0] bitByteAddr(input logic [7:0] bitAddr);
    if (bitAddr[7]) begin
      return {bitAddr[7:3], 3'b000};
    end
    return `CDM_BIT_RAM_BASE + {4'h0, bitAddr[6:3]};
  endfunction : bitByteAddr

  function automatic logic isLocalSfr(input logic [7:0] addr);
    return (addr == `CDM_STACK_TOP_PTR_ADDR) || (addr == `CDM_STORE_CTL_ADDR) ||
           (addr == `CDM_STATUS_WORD_ADDR);
  endfunction : isLocalSfr

  function automatic logic opIsNoOperation(input logic [7:0] code);
    return (code == `CDM_NO_OPERATION_OPCODE) || (code == `CDM_SPARE_OPCODE);
  endfunction : opIsNoOperation

  // Target byte decode for the current data access
  always_comb begin
    tgtAddr = 8'h00;
    tgtSfr = 1'b0;
    unique case (accMode)
      ACC_DIRECT: begin
        tgtAddr = accAddr;
        tgtSfr = accAddr[7];
      end
      ACC_INDIRECT: begin
        tgtAddr = ram_reg[bankRegAddr(statusWord_reg, {2'b00, accAddr[0]})];
        tgtSfr = 1'b0;
      end
      ACC_REGISTER: begin
        tgtAddr = bankRegAddr(statusWord_reg, accAddr[2:0]);
        tgtSfr = 1'b0;
      end
      ACC_BIT: begin
        tgtAddr = bitByteAddr(accAddr);
        tgtSfr = accAddr[7];
      end
      ACC_PUSH: begin
        tgtAddr = stackPtr_reg + 8'h01;
        tgtSfr = 1'b0;
      end
      ACC_POP: begin
        tgtAddr = stackPtr_reg;
        tgtSfr = 1'b0;
      end
      default: begin
        tgtAddr = 8'h00;
        tgtSfr = 1'b0;
      end
    endcase
  end

  // Old and new byte values of the target
  always_comb begin
    bitPos = accAddr[2:0];
    tgtLocal = tgtSfr && isLocalSfr(tgtAddr);
    unique case (tgtAddr)
      `CDM_STACK_TOP_PTR_ADDR: localValue = stackPtr_reg;
      `CDM_STORE_CTL_ADDR: localValue = storeCtl_reg;
      `CDM_STATUS_WORD_ADDR: localValue = statusWord_reg;
      default: localValue = 8'h00;
    endcase
    if (tgtSfr) begin
      oldValue = tgtLocal ? localValue : sfrRdData;
    end else begin
      oldValue = ram_reg[tgtAddr];
    end
    newValue = accWData;
    if (accMode == ACC_BIT) begin
      newValue = oldValue;
      newValue[bitPos] = accWBit;
    end
    doWrite = accReq && ((accWrite && (accMode != ACC_POP)) || (accMode == ACC_PUSH));
    sfrSel = accReq && tgtSfr && !tgtLocal;
    sfrAddr = sfrSel ? tgtAddr : 8'h00;
    sfrWe = sfrSel && doWrite;
    sfrWData = sfrWe ? newValue : 8'h00;
  end

  // Next state of storage, pointers and result registers
  always_comb begin
    ram_next = ram_reg;
    stackPtr_next = stackPtr_reg;
    statusWord_next = statusWord_reg;
    storeCtl_next = storeCtl_reg;
    rdValid_next = 1'b0;
    rdData_next = rdData_reg;
    rdBit_next = rdBit_reg;
    brValid_next = brReq;
    brTarget_next = brTarget_reg;
    noOp_next = opReq && opIsNoOperation(opCode);
    noOpPc_next = noOpPc_reg;
    progWrEn_next = 1'b0;
    xdataWrEn_next = 1'b0;
    wrAddr_next = wrAddr_reg;
    wrData_next = wrData_reg;

    if (accReq) begin
      if (!doWrite || (accMode == ACC_BIT)) begin
        rdValid_next = !doWrite;
        rdData_next = oldValue;
        rdBit_next = oldValue[bitPos];
      end
      if (doWrite) begin
        if (tgtLocal) begin
          unique case (tgtAddr)
            `CDM_STACK_TOP_PTR_ADDR: stackPtr_next = newValue;
            `CDM_STORE_CTL_ADDR: storeCtl_next = newValue;
            `CDM_STATUS_WORD_ADDR: statusWord_next = newValue;
            default: storeCtl_next = storeCtl_reg;
          endcase
        end else if (!tgtSfr) begin
          ram_next[tgtAddr] = newValue;
        end
      end
      if (accMode == ACC_PUSH) begin
        stackPtr_next = stackPtr_reg + 8'h01;
      end else if (accMode == ACC_POP) begin
        stackPtr_next = stackPtr_reg - 8'h01;
      end
    end

    if (brReq) begin
      unique case (brKind)
        BR_RELATIVE: brTarget_next = brNextPc + {{8{brOperand[7]}}, brOperand[7:0]};
        BR_PAGE: brTarget_next = {brNextPc[15:11], brOperand[10:0]};
        BR_LONG: brTarget_next = brOperand;
        default: brTarget_next = brNextPc;
      endcase
    end

    if (opReq && opIsNoOperation(opCode)) begin
      noOpPc_next = opPc + 16'h0001;
    end

    if (xdataWrReq) begin
      progWrEn_next = storeCtl_reg[`CDM_STORE_WRITE_EN_BIT];
      xdataWrEn_next = !storeCtl_reg[`CDM_STORE_WRITE_EN_BIT];
      wrAddr_next = xdataWrAddr;
      wrData_next = xdataWrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `CDM_RAM_DEPTH; i++) begin
        ram_reg[i] <= `CDM_RAM_RESET;
      end
      stackPtr_reg <= `CDM_STACK_TOP_PTR_RESET;
      statusWord_reg <= `CDM_STATUS_WORD_RESET;
      storeCtl_reg <= `CDM_STORE_CTL_RESET;
      rdValid_reg <= 1'b0;
      rdData_reg <= 8'h00;
      rdBit_reg <= 1'b0;
      brValid_reg <= 1'b0;
      brTarget_reg <= 16'h0000;
      noOp_reg <= 1'b0;
      noOpPc_reg <= 16'h0000;
      progWrEn_reg <= 1'b0;
      xdataWrEn_reg <= 1'b0;
      wrAddr_reg <= 16'h0000;
      wrData_reg <= 8'h00;
    end else begin
      ram_reg <= ram_next;
      stackPtr_reg <= stackPtr_next;
      statusWord_reg <= statusWord_next;
      storeCtl_reg <= storeCtl_next;
      rdValid_reg <= rdValid_next;
      rdData_reg <= rdData_next;
      rdBit_reg <= rdBit_next;
      brValid_reg <= brValid_next;
      brTarget_reg <= brTarget_next;
      noOp_reg <= noOp_next;
      noOpPc_reg <= noOpPc_next;
      progWrEn_reg <= progWrEn_next;
      xdataWrEn_reg <= xdataWrEn_next;
      wrAddr_reg <= wrAddr_next;
      wrData_reg <= wrData_next;
    end
  end

  assign accRdValid = rdValid_reg;
  assign accRdData = rdData_reg;
  assign accRdBit = rdBit_reg;
  assign stackTopPointer = stackPtr_reg;
  assign processorStatusWord = statusWord_reg;
  assign programStoreWriteControl = storeCtl_reg;
  assign brValid = brValid_reg;
  assign brTarget = brTarget_reg;
  assign opNoOperation = noOp_reg;
  assign opNoOperationNextPc = noOpPc_reg;
  assign progWrEn = progWrEn_reg;
  assign xdataWrEn = xdataWrEn_reg;
  assign memWrAddr = wrAddr_reg;
  assign memWrData = wrData_reg;

endmodule : cdm_data_memory
`default_nettype wire

// ---- src/cdm_pkg.sv ----
package cdm_pkg;

  typedef enum logic [2:0] {
    ACC_DIRECT,
    ACC_INDIRECT,
    ACC_REGISTER,
    ACC_BIT,
    ACC_PUSH,
    ACC_POP
  } cdm_access_type;

  typedef enum logic [1:0] {
    BR_RELATIVE,
    BR_PAGE,
    BR_LONG
  } cdm_branch_type;

endpackage : cdm_pkg

// ---- tb/cdm_data_memory_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdm_data_memory_checker
  import cdm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic accReq,
  input wire cdm_access_type accMode,
  input wire logic [7:0] accAddr,
  input wire logic sfrSel,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] stackTopPointer,
  input wire logic [7:0] programStoreWriteControl,
  input wire logic brReq,
  input wire cdm_branch_type brKind,
  input wire logic [15:0] brNextPc,
  input wire logic [15:0] brOperand,
  input wire logic [15:0] brTarget,
  input wire logic opReq,
  input wire logic [7:0] opCode,
  input wire logic [15:0] opPc,
  input wire logic opNoOperation,
  input wire logic [15:0] opNoOperationNextPc,
  input wire logic xdataWrReq,
  input wire logic progWrEn,
  input wire logic xdataWrEn
);
  wire logic [15:0] relSum = brNextPc + {{8{brOperand[7]}}, brOperand[7:0]};
  wire logic [15:0] pageSum = {brNextPc[15:11], brOperand[10:0]};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_rel; brReq && brKind == BR_RELATIVE |=> brTarget == $past(relSum); endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_page; brReq && brKind == BR_PAGE |=> brTarget == $past(pageSum); endproperty
  a_page: assert property (p_page) else $error("page target wrong");
  property p_long; brReq && brKind == BR_LONG |-> ##1 brTarget == $past(brOperand); endproperty
  a_long: assert property (p_long) else $error("long target wrong");
  property p_nop; opReq && opCode == 8'ha5 |=> opNoOperation && opNoOperationNextPc == $past(opPc) + 16'h1; endproperty
  a_nop: assert property (p_nop) else $error("spare opcode not idle");
  property p_prog; xdataWrReq |=> (progWrEn == $past(programStoreWriteControl[0])) && (xdataWrEn != progWrEn); endproperty
  a_prog: assert property (p_prog) else $error("program write steering wrong");
  property p_sfr; accReq && accMode == ACC_DIRECT && accAddr == 8'h90 |-> sfrSel && sfrAddr == 8'h90; endproperty
  a_sfr: assert property (p_sfr) else $error("direct high not on sfr bus");
  property p_ind; accReq && accMode == ACC_INDIRECT |-> !sfrSel; endproperty
  a_ind: assert property (p_ind) else $error("indirect reached sfr bus");
  property p_push; accReq && accMode == ACC_PUSH |=> stackTopPointer == $past(stackTopPointer) + 8'h1; endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");
  property p_pop; accReq && accMode == ACC_POP |=> stackTopPointer == $past(stackTopPointer) - 8'h1; endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  c_push: cover property (accReq && accMode == ACC_PUSH);
  c_bit: cover property (accReq && accMode == ACC_BIT);
  c_prog: cover property (xdataWrReq && programStoreWriteControl[0]);
endmodule : cdm_data_memory_checker
bind cdm_data_memory cdm_data_memory_checker chk_u (.*);
`default_nettype wire

// ---- tb/cdm_data_memory_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdm_data_memory_tb
  import cdm_pkg::*;
;
  logic ref_clk = 0, rstn = 0, accReq = 0, accWrite = 0, accWBit = 0, brReq = 0, opReq = 0, xdataWrReq = 0;
  cdm_access_type accMode = ACC_DIRECT;
  cdm_branch_type brKind = BR_LONG;
  logic [7:0] accAddr = 0, accWData = 0, opCode = 0, xdataWrData = 0;
  logic [15:0] brNextPc = 0, brOperand = 0, opPc = 0, xdataWrAddr = 0;
  logic [7:0] accRdData, sfrAddr, sfrWData, sfrRdData, stackTopPointer, processorStatusWord;
  logic [7:0] programStoreWriteControl, memWrData;
  logic [15:0] brTarget, opNoOperationNextPc, memWrAddr;
  logic accRdValid, accRdBit, sfrSel, sfrWe, brValid, opNoOperation, progWrEn, xdataWrEn;
  int n_mismatch = 0, cmp_count = 0;
  cdm_data_memory dut_u (.*);
  cdm_sfr_model sfr_u (.*);
  always #10 ref_clk = ~ref_clk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task step;
    @(posedge ref_clk);
    accReq <= 0; brReq <= 0; opReq <= 0; xdataWrReq <= 0;
    #1;
  endtask : step
  task automatic acc(input cdm_access_type m, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    accReq <= 1; accMode <= m; accWrite <= w; accAddr <= a; accWData <= d; accWBit <= d[0];
    step;
  endtask : acc
  task automatic br(input cdm_branch_type k, input logic [15:0] n, input logic [15:0] o, input logic [15:0] e);
    @(posedge ref_clk);
    brReq <= 1; brKind <= k; brNextPc <= n; brOperand <= o;
    step;
    chk(brValid, 1);
    chk(brTarget, e);
  endtask : br
  task automatic xw(input logic [7:0] c, input logic [1:0] e);
    acc(ACC_DIRECT, 1, 8'h8f, c);
    @(posedge ref_clk);
    xdataWrReq <= 1; xdataWrAddr <= 16'hfbff; xdataWrData <= 8'h77;
    step;
    chk({progWrEn, xdataWrEn}, e);
    chk({memWrAddr, memWrData}, {16'hfbff, 8'h77});
    chk(programStoreWriteControl, c);
  endtask : xw
  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    #500000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    #1;
    chk(stackTopPointer, 8'h07);
    chk({processorStatusWord, programStoreWriteControl}, 16'h0);
    acc(ACC_PUSH, 1, 0, 8'h5a);
    chk(stackTopPointer, 8'h08);
    acc(ACC_DIRECT, 1, 8'hd0, 8'h08);
    chk(processorStatusWord, 8'h08);
    acc(ACC_REGISTER, 0, 0, 0);
    chk(accRdData, 8'h5a);
    acc(ACC_POP, 0, 0, 0);
    chk({accRdData, stackTopPointer}, 16'h5a07);
    acc(ACC_REGISTER, 1, 1, 8'h90);
    acc(ACC_INDIRECT, 1, 1, 8'h33);
    acc(ACC_DIRECT, 1, 8'h90, 8'hc3);
    acc(ACC_INDIRECT, 0, 1, 0);
    chk(accRdData, 8'h33);
    acc(ACC_DIRECT, 0, 8'h90, 0);
    chk(accRdData, 8'hc3);
    acc(ACC_DIRECT, 0, 8'h09, 0);
    chk(accRdData, 8'h90);
    acc(ACC_DIRECT, 1, 8'h22, 0);
    acc(ACC_BIT, 1, 8'h13, 1);
    acc(ACC_DIRECT, 0, 8'h22, 0);
    chk(accRdData, 8'h08);
    acc(ACC_BIT, 0, 8'h13, 0);
    chk({accRdValid, accRdBit}, 2'b11);
    acc(ACC_BIT, 1, 8'h92, 1);
    acc(ACC_DIRECT, 0, 8'h90, 0);
    chk(accRdData, 8'hc7);
    acc(ACC_DIRECT, 1, 8'h81, 8'h8f);
    acc(ACC_PUSH, 1, 0, 8'h66);
    chk(stackTopPointer, 8'h90);
    acc(ACC_INDIRECT, 0, 1, 0);
    chk(accRdData, 8'h66);
    acc(ACC_DIRECT, 0, 8'h90, 0);
    chk(accRdData, 8'hc7);
    br(BR_RELATIVE, 16'h1000, 16'h00fe, 16'h0ffe);
    br(BR_PAGE, 16'h27fe, 16'h0123, 16'h2123);
    br(BR_LONG, 16'h1000, 16'hbeef, 16'hbeef);
    @(posedge ref_clk);
    opReq <= 1; opCode <= 8'ha5; opPc <= 16'h0100;
    step;
    chk({opNoOperation, opNoOperationNextPc}, 17'h10101);
    @(posedge ref_clk);
    opReq <= 1; opCode <= 8'h12;
    step;
    chk(opNoOperation, 0);
    @(posedge ref_clk);
    opReq <= 1; opCode <= 8'h00; opPc <= 16'h0200;
    step;
    chk({opNoOperation, opNoOperationNextPc}, 17'h10201);
    xw(8'h01, 2'b10);
    xw(8'h00, 2'b01);
    end_sim;
  end
endmodule : cdm_data_memory_tb
`default_nettype wire

// ---- tb/cdm_sfr_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdm_sfr_model (
  input wire logic ref_clk,
  input wire logic sfrSel,
  input wire logic sfrWe,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWData,
  output logic [7:0] sfrRdData
);
  logic [7:0] mem [256];
  logic [7:0] lastRd = 8'h00;
  // Unselected bus shows inverse of last value
  assign sfrRdData = sfrSel ? mem[sfrAddr] : ~lastRd;
  always @(posedge ref_clk) begin
    if (sfrSel) lastRd <= mem[sfrAddr];
    if (sfrWe) mem[sfrAddr] <= sfrWData;
  end
endmodule : cdm_sfr_model
`default_nettype wire
